// *** core/sfp_fifo.sv ***
// Synchronous FIFO with valid/ready on both sides
`timescale 1ns/100ps
module sfp_fifo #(
  parameter int WIDTH = 21,
  parameter int DEPTH = 16
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int PW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0] wr_ptr;
  logic [PW-1:0] rd_ptr;
  logic [PW:0] count;
  logic [PW-1:0] next_wr_ptr;
  logic [PW-1:0] next_rd_ptr;
  logic [PW:0] next_count;
  logic push;
  logic pop;

  assign in_ready = count != (PW+1)'(DEPTH);
  assign out_valid = count != '0;
  assign out_data = mem[rd_ptr];
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;

  always_comb begin
    next_wr_ptr = wr_ptr;
    next_rd_ptr = rd_ptr;
    next_count = count;
    if (push) begin
      next_wr_ptr = (wr_ptr == PW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
    end
    if (pop) begin
      next_rd_ptr = (rd_ptr == PW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
    end
    if (push && !pop) begin
      next_count = count + 1'b1;
    end else if (pop && !push) begin
      next_count = count - 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      count <= next_count;
    end
  end

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end
endmodule : sfp_fifo

// *** core/sfp_pkg.sv ***
// Constants, opcodes and state codes for the serial memory slave port
package sfp_pkg;
  localparam int ADDR_W = 13;
  localparam int MEM_DEPTH = 8192;
  localparam int FIFO_DEPTH = 16;
  localparam int WQ_W = ADDR_W + 8;
  // Command opcodes (values arbitrary but conventional)
  localparam logic [7:0] OP_WR_EN = 8'h06;
  localparam logic [7:0] OP_WR_DIS = 8'h04;
  localparam logic [7:0] OP_SR_READ = 8'h05;
  localparam logic [7:0] OP_SR_WRITE = 8'h01;
  localparam logic [7:0] OP_MEM_READ = 8'h03;
  localparam logic [7:0] OP_MEM_WRITE = 8'h02;
  // Status register layout
  localparam int SR_WEL = 1;
  localparam int SR_BP_LO = 2;
  localparam int SR_BP_HI = 3;
  localparam int SR_PPE = 7;
  localparam logic [7:0] SR_WR_MASK = 8'h8c;
  localparam logic [7:0] SR_RESET = 8'h00;
  localparam logic [2:0] BIT_LAST = 3'h7;
  // Pin sampler idle levels: select, protect and hold high, clock and data low
  localparam logic [4:0] PIN_IDLE = 5'h1c;
  typedef enum logic [7:0] {
    ST_IDLE = 8'h01,
    ST_CMD = 8'h02,
    ST_ADDR = 8'h04,
    ST_WR = 8'h08,
    ST_RD = 8'h10,
    ST_SR_RD = 8'h20,
    ST_SR_WR = 8'h40,
    ST_IGNORE = 8'h80
  } sfp_state_e;
endpackage : sfp_pkg

// *** core/sfp_slave.sv ***
// Serial memory slave port: pin sampling, command decode, array and status
`timescale 1ns/100ps
module sfp_slave
  import sfp_pkg::*;
#(
  parameter int DEPTH = MEM_DEPTH,
  parameter int WQ_DEPTH = FIFO_DEPTH
) (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic cs_n,
  input wire logic sck,
  input wire logic si,
  input wire logic wp_n,
  input wire logic hold_n,
  output logic so,
  output logic so_oe,
  output logic standby,
  output logic [7:0] status
);
  logic rst_m;
  logic rst_n;
  logic [4:0] pin_m;
  logic [4:0] pin_s;
  logic sck_d;
  logic cs_s;
  logic sck_s;
  logic si_s;
  logic wp_s;
  logic hold_s;

  sfp_state_e state;
  sfp_state_e next_state;
  logic cs_eff;
  logic next_cs_eff;
  logic [2:0] bits;
  logic [2:0] next_bits;
  logic [6:0] shin;
  logic [6:0] next_shin;
  logic [ADDR_W-1:0] addr;
  logic [ADDR_W-1:0] next_addr;
  logic addr_lo;
  logic next_addr_lo;
  logic is_read;
  logic next_is_read;
  logic [2:0] ocnt;
  logic [2:0] next_ocnt;
  logic so_on;
  logic next_so_on;
  logic next_so;
  logic [7:0] sr;
  logic [7:0] next_sr;
  logic wr_cmd;
  logic next_wr_cmd;
  logic [7:0] rd_buf;

  logic sck_rise;
  logic sck_fall;
  logic byte_done;
  logic [7:0] byte_val;
  logic prot;
  logic wq_valid;
  logic wq_ready;
  logic [WQ_W-1:0] wq_data;
  logic dq_valid;
  logic dq_ready;
  logic [WQ_W-1:0] dq_data;
  logic [7:0] mem [DEPTH];

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      rst_m <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_m <= 1'b1;
      rst_n <= rst_m;
    end
  end

  // Two-flop sampling of every pin
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_m <= PIN_IDLE;
      pin_s <= PIN_IDLE;
      sck_d <= 1'b0;
    end else begin
      pin_m <= {cs_n, wp_n, hold_n, sck, si};
      pin_s <= pin_m;
      sck_d <= pin_s[1];
    end
  end

  assign cs_s = pin_s[4];
  assign wp_s = pin_s[3];
  assign hold_s = pin_s[2];
  assign sck_s = pin_s[1];
  assign si_s = pin_s[0];

  // Edges only count while selected and not held
  assign sck_rise = sck_s & ~sck_d & hold_s & ~cs_eff;
  assign sck_fall = ~sck_s & sck_d & hold_s & ~cs_eff;
  assign byte_done = sck_rise && bits == BIT_LAST;
  assign byte_val = {shin, si_s};

  always_comb begin
    unique case (sr[SR_BP_HI:SR_BP_LO])
      2'h1: prot = addr[ADDR_W-1 -: 2] == 2'h3;
      2'h2: prot = addr[ADDR_W-1];
      2'h3: prot = 1'b1;
      2'h0: prot = 1'b0;
    endcase
  end

  assign wq_valid = state == ST_WR && byte_done && sr[SR_WEL] && !prot;
  assign wq_data = {addr, byte_val};

  always_comb begin
    next_state = state;
    next_cs_eff = hold_s ? cs_s : cs_eff;
    next_bits = bits;
    next_shin = shin;
    next_addr = addr;
    next_addr_lo = addr_lo;
    next_is_read = is_read;
    next_ocnt = ocnt;
    next_so_on = so_on;
    next_so = so;
    next_sr = sr;
    next_wr_cmd = wr_cmd;
    if (cs_eff) begin
      next_state = ST_IDLE;
      next_bits = 3'h0;
      next_so_on = 1'b0;
      if (wr_cmd) begin
        next_sr[SR_WEL] = 1'b0;
        next_wr_cmd = 1'b0;
      end
    end else begin
      if (sck_rise) begin
        next_shin = byte_val[6:0];
        next_bits = bits + 3'h1;
      end
      unique case (state)
        ST_IDLE: begin
          next_state = ST_CMD;
          next_ocnt = 3'h0;
          next_addr_lo = 1'b0;
        end
        ST_CMD: begin
          if (byte_done) begin
            next_state = ST_IGNORE;
            if (byte_val == OP_WR_EN) begin
              next_sr[SR_WEL] = 1'b1;
            end else if (byte_val == OP_WR_DIS) begin
              next_sr[SR_WEL] = 1'b0;
            end else if (byte_val == OP_SR_READ) begin
              next_state = ST_SR_RD;
            end else if (byte_val == OP_SR_WRITE) begin
              next_state = ST_SR_WR;
              next_wr_cmd = 1'b1;
            end else if (byte_val == OP_MEM_READ || byte_val == OP_MEM_WRITE) begin
              next_state = ST_ADDR;
              next_is_read = byte_val == OP_MEM_READ;
              next_wr_cmd = byte_val == OP_MEM_WRITE;
            end
          end
        end
        ST_ADDR: begin
          if (byte_done) begin
            if (!addr_lo) begin
              next_addr[ADDR_W-1:8] = byte_val[ADDR_W-9:0];
              next_addr_lo = 1'b1;
            end else begin
              next_addr[7:0] = byte_val;
              next_state = is_read ? ST_RD : ST_WR;
            end
          end
        end
        ST_WR: begin
          if (byte_done) begin
            next_addr = addr + 1'b1;
          end
        end
        ST_RD, ST_SR_RD: begin
          if (sck_fall) begin
            next_so = rd_buf[~ocnt];
            next_so_on = 1'b1;
            next_ocnt = ocnt + 3'h1;
            if (state == ST_RD && ocnt == BIT_LAST) begin
              next_addr = addr + 1'b1;
            end
          end
        end
        ST_SR_WR: begin
          if (byte_done) begin
            next_state = ST_IGNORE;
            if (sr[SR_WEL] && !(!wp_s && sr[SR_PPE])) begin
              next_sr = (sr & ~SR_WR_MASK) | (byte_val & SR_WR_MASK);
            end
          end
        end
        ST_IGNORE: begin
          next_state = ST_IGNORE;
        end
      endcase
    end
  end

  // Only the sampled pins change state, so clock pauses are harmless
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= ST_IDLE;
      cs_eff <= 1'b1;
      bits <= 3'h0;
      shin <= 7'h00;
      addr <= '0;
      addr_lo <= 1'b0;
      is_read <= 1'b0;
      ocnt <= 3'h0;
      so_on <= 1'b0;
      so <= 1'b0;
      sr <= SR_RESET;
      wr_cmd <= 1'b0;
    end else begin
      state <= next_state;
      cs_eff <= next_cs_eff;
      bits <= next_bits;
      shin <= next_shin;
      addr <= next_addr;
      addr_lo <= next_addr_lo;
      is_read <= next_is_read;
      ocnt <= next_ocnt;
      so_on <= next_so_on;
      so <= next_so;
      sr <= next_sr;
      wr_cmd <= next_wr_cmd;
    end
  end

  assign so_oe = so_on & hold_s & ~cs_eff & (state == ST_RD || state == ST_SR_RD);
  assign standby = cs_eff;
  assign status = sr;

  // Write queue between the serial side and the array
  sfp_fifo #(
    .WIDTH(WQ_W),
    .DEPTH(WQ_DEPTH)
  ) u_wq (
    .clk(core_clk),
    .rst_n(rst_n),
    .in_valid(wq_valid),
    .in_ready(wq_ready),
    .in_data(wq_data),
    .out_valid(dq_valid),
    .out_ready(dq_ready),
    .out_data(dq_data)
  );

  // Single array port: reads win, writes wait in the queue
  assign dq_ready = state != ST_RD;

  always_ff @(posedge core_clk) begin
    if (dq_valid && dq_ready) begin
      mem[dq_data[WQ_W-1:8]] <= dq_data[7:0];
    end
  end

  always_ff @(posedge core_clk) begin
    rd_buf <= (state == ST_SR_RD) ? sr : mem[addr];
  end
endmodule : sfp_slave

// *** verif/sfp_master_model.sv ***
// Behavioural SPI master for the serial memory port
`timescale 1ns/100ps
module sfp_master_model (
  output logic cs_n,
  output logic sck,
  output logic si,
  output logic hold_n,
  input wire logic so,
  input wire logic so_oe
);
  logic cpol;
  initial begin
    cpol = 1'b0;
    cs_n = 1'b1;
    sck = 1'b0;
    si = 1'b0;
    hold_n = 1'b1;
  end
  task sel();
    sck = cpol;
    #400 cs_n = 1'b0;
    #400;
  endtask : sel
  task desel();
    #400 cs_n = 1'b1;
    si = ~si;
    #400;
  endtask : desel
  // Hold moves only once the clock has sat low for a while
  task hold(input logic h);
    #200;
    hold_n = h;
    #400;
  endtask : hold
  // Undriven so reads as unknown so a float never passes as data
  task bit1(input logic b, output logic r);
    if (sck) begin
      sck = 1'b0;
    end
    si = b;
    #200 sck = 1'b1;
    r = so_oe ? so : 1'bx;
    #200;
  endtask : bit1
  task xfer(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) bit1(tx[i], rx[i]);
    if (sck != cpol) begin
      sck = cpol;
    end
  endtask : xfer
endmodule : sfp_master_model

// *** verif/sfp_slave_assertions.sv ***
// Concurrent checks on the serial memory port pins
`timescale 1ns/100ps
module sfp_slave_assertions
  import sfp_pkg::*;
(
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic cs_n,
  input wire logic sck,
  input wire logic si,
  input wire logic wp_n,
  input wire logic hold_n,
  input wire logic so,
  input wire logic so_oe,
  input wire logic standby,
  input wire logic [7:0] status
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!resetn);
  // Depths allow for the pin synchronisers
  chk_desel_float: assert property (cs_n [*6] |-> !so_oe)
    else $error("so enabled while deselected");
  chk_standby_high: assert property ((cs_n && hold_n) [*6] |-> standby)
    else $error("standby low while deselected");
  chk_standby_low: assert property ((!cs_n && hold_n) [*6] |-> !standby)
    else $error("standby high while selected");
  chk_hold_float: assert property (!hold_n [*6] |-> !so_oe)
    else $error("so enabled during hold");
  chk_so_launch: assert property (so_oe && $changed(so) |-> !$past(sck, 3))
    else $error("so changed away from a falling clock");
  chk_oe_rise: assert property ($rose(so_oe) |-> !$past(cs_n, 3) && !$past(sck, 3))
    else $error("so enable rose outside a read");
  chk_status_quiet: assert property ($changed(status) |-> !$past(cs_n, 6))
    else $error("status changed while deselected");
  chk_wp_lock: assert property (!wp_n [*5] ##0 $past(status[SR_PPE]) |->
    $stable(status[7:2]))
    else $error("status written while pin protected");
endmodule : sfp_slave_assertions

// *** verif/sfp_slave_bench.sv ***
// Self-checking bench for the serial memory slave port
`timescale 1ns/100ps
module sfp_slave_bench;
  import sfp_pkg::*;
  logic core_clk, resetn, wp_n, cs_n, sck, si, hold_n, so, so_oe, standby, b;
  logic [7:0] status, rx, r0, r1;
  int fail_count = 0;
  int n_tests = 0;
  sfp_slave i_dut (.core_clk(core_clk), .resetn(resetn), .cs_n(cs_n), .sck(sck), .si(si),
    .wp_n(wp_n), .hold_n(hold_n), .so(so), .so_oe(so_oe), .standby(standby), .status(status));
  sfp_master_model i_m (.cs_n(cs_n), .sck(sck), .si(si), .hold_n(hold_n), .so(so),
    .so_oe(so_oe));
  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end
  task check(input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fail_count++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task end_of_test();
    if (fail_count == 0 && n_tests > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : end_of_test
  task op(input logic [7:0] c);
    i_m.sel();
    i_m.xfer(c, rx);
    i_m.desel();
  endtask : op
  // Clock pause mid-command must not disturb the transfer
  task wr(input logic [15:0] a, input logic [7:0] d0, input logic [7:0] d1);
    i_m.sel();
    i_m.xfer(OP_MEM_WRITE, rx);
    i_m.xfer(a[15:8], rx);
    i_m.xfer(a[7:0], rx);
    #3000;
    i_m.xfer(d0, rx);
    i_m.xfer(d1, rx);
    i_m.desel();
  endtask : wr
  task rd(input logic [15:0] a);
    i_m.sel();
    i_m.xfer(OP_MEM_READ, rx);
    i_m.xfer(a[15:8], rx);
    i_m.xfer(a[7:0], rx);
    i_m.xfer(8'h00, r0);
    i_m.xfer(8'h00, r1);
    i_m.desel();
  endtask : rd
  task sr(input logic [7:0] v);
    op(OP_WR_EN);
    i_m.sel();
    i_m.xfer(OP_SR_WRITE, rx);
    i_m.xfer(v, rx);
    i_m.desel();
  endtask : sr
  task t_rw();
    for (int m = 0; m < 2; m++) begin
      i_m.cpol = m[0];
      op(OP_WR_EN);
      wr(16'hffff, 8'ha5 ^ m[7:0], 8'h3c);
      rd(16'h1fff);
      check(r0, 8'ha5 ^ m[7:0]);
      check(r1, 8'h3c);
      check(status, 8'h00);
    end
    i_m.cpol = 1'b0;
  endtask : t_rw
  task t_wel();
    op(OP_WR_EN);
    wr(16'h0010, 8'h55, 8'h56);
    op(OP_WR_EN);
    i_m.sel();
    i_m.xfer(OP_SR_READ, rx);
    i_m.xfer(8'h00, rx);
    i_m.desel();
    check(rx, 8'h02);
    op(OP_WR_DIS);
    check(status, 8'h00);
    wr(16'h0010, 8'h66, 8'h67);
    rd(16'h0010);
    check(r0, 8'h55);
  endtask : t_wel
  task t_partial();
    op(OP_WR_EN);
    i_m.sel();
    i_m.xfer(OP_MEM_WRITE, rx);
    i_m.xfer(8'h00, rx);
    i_m.xfer(8'h11, rx);
    for (int i = 0; i < 4; i++) i_m.bit1(1'b1, b);
    i_m.desel();
    rd(16'h0011);
    check(r0, 8'h56);
  endtask : t_partial
  task t_bad();
    i_m.sel();
    i_m.xfer(8'hab, rx);
    i_m.xfer(OP_WR_EN, rx);
    i_m.xfer(OP_SR_READ, rx);
    check(rx, 8'hxx);
    check({7'h00, standby}, 8'h00);
    i_m.desel();
    check({status[7:1], standby}, 8'h01);
  endtask : t_bad
  task t_hold();
    i_m.sel();
    i_m.xfer(OP_MEM_READ, rx);
    i_m.xfer(8'he0, rx);
    i_m.xfer(8'h10, rx);
    i_m.hold(1'b0);
    i_m.xfer(8'hff, rx);
    check(rx, 8'hxx);
    i_m.hold(1'b1);
    i_m.xfer(8'h00, rx);
    check(rx, 8'h55);
    i_m.desel();
  endtask : t_hold
  task t_wp();
    op(OP_WR_EN);
    wr(16'h17ff, 8'h11, 8'h22);
    for (int k = 1; k < 4; k++) begin
      sr({1'b1, 3'h0, k[1:0], 2'h0});
      check(status, {1'b1, 3'h0, k[1:0], 2'h0});
      op(OP_WR_EN);
      wr(16'h17ff, {6'h10, k[1:0]}, 8'h33);
      rd(16'h17ff);
      check(r0, 8'h41);
      check(r1, 8'h22);
    end
    op(OP_WR_EN);
    wr(16'h0010, 8'h77, 8'h78);
    rd(16'h0010);
    check(r0, 8'h55);
    wp_n = 1'b0;
    sr(8'h00);
    check(status, 8'h8c);
    wp_n = 1'b1;
    sr(8'h00);
    check(status, 8'h00);
  endtask : t_wp
  initial begin
    resetn = 1'b0;
    wp_n = 1'b1;
    repeat (6) @(posedge core_clk);
    @(negedge core_clk);
    resetn = 1'b1;
    repeat (6) @(negedge core_clk);
    check({status[6:0], so_oe}, 8'h00);
    t_rw();
    t_wel();
    t_partial();
    t_bad();
    t_hold();
    t_wp();
    end_of_test();
  end
  initial begin
    #3000000;
    fail_count++;
    end_of_test();
  end
endmodule : sfp_slave_bench
bind sfp_slave sfp_slave_assertions i_chk (.core_clk(core_clk), .resetn(resetn),
  .cs_n(cs_n), .sck(sck), .si(si), .wp_n(wp_n), .hold_n(hold_n), .so(so), .so_oe(so_oe),
  .standby(standby), .status(status));
